// *** include/pin_mux_pkg.sv ***
// package for the terminal function mux slice: register map, field
// positions, selection codes, reset values and pad control carrier.
// assumes nothing beyond a systemverilog compiler.
package pin_mux_pkg;

    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [3:0] FUNC_SEL_8_OFFSET = 4'h0;
    localparam logic [3:0] FUNC_SEL_9_OFFSET = 4'h4;
    localparam logic [3:0] FUNC_SEL_A_OFFSET = 4'h8;
    localparam logic [3:0] PAD_STATUS_OFFSET = 4'hc;
    localparam logic [31:0] FUNC_SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // ********************************************************
    // field positions (low bit of each three-bit field)
    // ********************************************************
    localparam int BOOT_SEL_LSB = 27;      // reg8[29:27]
    localparam int HOST_RST_LSB = 0;       // reg9[2:0]
    localparam int HIZ_CLK_LSB = 3;        // reg9[5:3]
    localparam int LOW_RTS_LSB = 12;       // reg9[14:12]
    localparam int LOW_TX_LSB = 21;        // reg9[23:21]
    localparam int MCS_DOUT_LSB = 24;      // reg9[26:24]
    localparam int BCLK_REQ_LSB = 27;      // reg9[29:27]
    localparam int BCLK_OUT_LSB = 0;       // regA[2:0]
    localparam int MCS_SYNC_LSB = 3;       // regA[5:3]

    // ********************************************************
    // selection codes
    // ********************************************************
    localparam logic [2:0] SEL_0 = 3'h0;
    localparam logic [2:0] SEL_1 = 3'h1;
    localparam logic [2:0] SEL_2 = 3'h2;

    // ********************************************************
    // deselected input levels
    // ********************************************************
    localparam logic DESEL_BCLK_REQ = 1'b0;
    localparam logic DESEL_UART_C_CTS = 1'b0;
    localparam logic DESEL_UART_A_DSR = 1'b1;
    localparam logic DESEL_MCS_SYNC = 1'b0;
    localparam logic DESEL_DEFAULT = 1'b0;

    // ********************************************************
    // pad control carrier: output enable is active low
    // ********************************************************
    typedef struct packed {
        logic out;
        logic oe_n;
    } pad_drive_t;

    localparam pad_drive_t PAD_HIZ = '{out: 1'b0, oe_n: 1'b1};
    localparam pad_drive_t PAD_LOW = '{out: 1'b0, oe_n: 1'b0};

endpackage

// *** core/sync_three.sv ***
// three-flop input synchroniser with agreement filter.
// assumes a single clock domain on i_clk; input is asynchronous.
`timescale 1ns/10ps
module sync_three #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_async,
    output logic o_level
);

    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic level_reg;
    logic level_next;

    // shift; level only moves when stages two and three agree
    always_comb begin
        stage_next = {stage_reg[1:0], i_async};
        level_next = level_reg;
        if (stage_reg[1] == stage_reg[2]) begin
            level_next = stage_reg[2];
        end
    end

    // first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stage_reg <= {3{RESET_VAL}};
            level_reg <= RESET_VAL;
        end else begin
            stage_reg <= stage_next;
            level_reg <= level_next;
        end
    end

    assign o_level = level_reg;

endmodule

// *** core/out_pad_cell.sv ***
// registered output pad cell: function, battery-fail gating, tri-state.
// assumes all inputs are on i_clk; reset value given by parameters.
`timescale 1ns/10ps
module out_pad_cell
    import pin_mux_pkg::*;
#(
    parameter logic GATE_ON_FAIL = 1'b1,
    parameter logic HIZ_ON_FAIL = 1'b0,
    parameter pad_drive_t RESET_DRIVE = PAD_LOW
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_fail,
    input wire logic i_gate2,
    input wire pad_drive_t i_func,
    output pad_drive_t o_pad
);

    pad_drive_t pad_reg;
    pad_drive_t pad_next;

    // gating forces out low and keeps oe_n; tri-state class floats instead
    always_comb begin
        pad_next = i_func;
        if (i_fail && GATE_ON_FAIL) begin
            pad_next.out = 1'b0;
        end
        if (i_gate2) begin
            pad_next.out = 1'b0;
        end
        if (i_fail && HIZ_ON_FAIL) begin
            pad_next = PAD_HIZ;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pad_reg <= RESET_DRIVE;
        end else begin
            pad_reg <= pad_next;
        end
    end

    assign o_pad = pad_reg;

endmodule

// *** core/terminal_function_mux_slice.sv ***
// terminal function mux slice: selection registers and pad routing.
// assumes pads resolve out/oe_n outside; peripherals on i_clk.
//
// Summary of operation
// - each muxed terminal has its own three-bit field in a select register.
// - reg8[29:27] routes boot select, port-3 receive data or usb suspend.
// - reg9[2:0] drives host reset, port-3 transmit data or usb se0.
// - reg9[5:3] floats, carries port-3 transmit clock or usb tx enable.
// - reg9[14:12] drives low or uart a request-to-send.
// - reg9[23:21] drives low or uart a transmit data.
// - reg9[26:24] drives serial a data, or usb tx data (or uart a tx).
// - reg9[29:27] feeds bus clock request, uart c cts or uart a dsr.
// - regA[2:0] drives bus clock, uart c rts or uart a dtr.
// - regA[5:3] carries two-way serial a sync or usb plus receive.
// - in reset emulation and high-z terminals float, inputs stay inputs.
// - in reset host reset, reset out, bus clock, data and lows drive 0.
// - gating-class terminals are gated while battery fail is high.
// - tri-state-class terminals float while battery fail is high.
// - scannable terminals pass through the boundary-scan chain.
// - second-class terminals are gated by general io nine and io three.
`timescale 1ns/10ps
module terminal_function_mux_slice
    import pin_mux_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // control inputs and scan output
    input wire logic i_battery_fail_input,
    input wire logic i_general_io_nine,
    input wire logic i_processor_io_three,
    input wire logic i_scan_mode,
    input wire logic i_scan_shift,
    input wire logic i_scan_in,
    output logic o_scan_out,
    // pins
    input wire logic i_boot_pin,
    output pad_drive_t o_boot_pad,
    output pad_drive_t o_host_rst_pad,
    output pad_drive_t o_tclk_pad,
    input wire logic i_tclk_pin,
    output pad_drive_t o_rts_pad,
    output pad_drive_t o_tx_pad,
    output pad_drive_t o_mcs_dout_pad,
    input wire logic i_breq_pin,
    output pad_drive_t o_bclk_pad,
    output pad_drive_t o_sync_pad,
    input wire logic i_sync_pin,
    // peripheral outputs towards the pins
    input wire logic i_usb_port1_suspend_out,
    input wire logic i_host_reset_out,
    input wire logic i_serial_port3_transmit_data,
    input wire logic i_usb_port1_single_ended_zero,
    input wire logic i_serial_port3_transmit_clock,
    input wire logic i_serial_port3_clock_dir_n,
    input wire logic i_usb_port1_transmit_enable,
    input wire logic i_uart_a_request_to_send,
    input wire logic i_uart_a_transmit,
    input wire logic i_multichannel_serial_a_data_out,
    input wire logic i_usb_port1_transmit_data,
    input wire logic i_uart_a_tx_alt,
    input wire logic i_bus_clock_out,
    input wire logic i_uart_c_request_to_send,
    input wire logic i_uart_a_data_terminal_ready,
    input wire logic i_multichannel_serial_a_sync,
    input wire logic i_sync_dir_n,
    // peripheral inputs from the pins
    output logic o_boot_select_input,
    output logic o_serial_port3_receive_data,
    output logic o_serial_port3_clock_in,
    output logic o_bus_clock_request,
    output logic o_uart_c_clear_to_send,
    output logic o_uart_a_data_set_ready,
    output logic o_multichannel_serial_a_sync,
    output logic o_usb_port1_plus_receive
);

    // ********************************************************
    // select registers and read port
    // ********************************************************
    logic [31:0] sel8_reg;
    logic [31:0] sel8_next;
    logic [31:0] sel9_reg;
    logic [31:0] sel9_next;
    logic [31:0] selA_reg;
    logic [31:0] selA_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic fail_s;
    logic gio9_s;
    logic pio3_s;

    // reserved codes are stored as written; software must avoid them
    always_comb begin
        sel8_next = sel8_reg;
        sel9_next = sel9_reg;
        selA_next = selA_reg;
        rdata_next = READ_UNMAPPED;
        if (i_wr) begin
            unique case (i_addr)
                FUNC_SEL_8_OFFSET: sel8_next = i_wdata;
                FUNC_SEL_9_OFFSET: sel9_next = i_wdata;
                FUNC_SEL_A_OFFSET: selA_next = i_wdata;
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                FUNC_SEL_8_OFFSET: rdata_next = sel8_reg;
                FUNC_SEL_9_OFFSET: rdata_next = sel9_reg;
                FUNC_SEL_A_OFFSET: rdata_next = selA_reg;
                PAD_STATUS_OFFSET: rdata_next = {29'h0, pio3_s, gio9_s,
                    fail_s};
                default: rdata_next = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sel8_reg <= FUNC_SEL_RESET;
            sel9_reg <= FUNC_SEL_RESET;
            selA_reg <= FUNC_SEL_RESET;
            rdata_reg <= READ_UNMAPPED;
        end else begin
            sel8_reg <= sel8_next;
            sel9_reg <= sel9_next;
            selA_reg <= selA_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;

    // ********************************************************
    // input synchronisers for pins and gating controls
    // ********************************************************
    logic boot_s;
    logic tclk_s;
    logic breq_s;
    logic sync_s;

    sync_three u_sync_fail (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_async(i_battery_fail_input), .o_level(fail_s));
    sync_three u_sync_gio9 (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_async(i_general_io_nine), .o_level(gio9_s));
    sync_three u_sync_pio3 (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_async(i_processor_io_three), .o_level(pio3_s));
    sync_three u_sync_boot (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_async(i_boot_pin), .o_level(boot_s));
    sync_three u_sync_tclk (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_async(i_tclk_pin), .o_level(tclk_s));
    sync_three u_sync_breq (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_async(i_breq_pin), .o_level(breq_s));
    sync_three u_sync_sync (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_async(i_sync_pin), .o_level(sync_s));

    // ********************************************************
    // output function selection
    // ********************************************************
    logic [2:0] f_boot, f_hrst, f_tclk, f_rts, f_tx, f_dout, f_breq;
    logic [2:0] f_bclk, f_sync;
    pad_drive_t d_boot;
    pad_drive_t d_hrst;
    pad_drive_t d_tclk;
    pad_drive_t d_rts;
    pad_drive_t d_tx;
    pad_drive_t d_dout;
    pad_drive_t d_bclk;
    pad_drive_t d_sync;
    logic gate2;

    assign f_boot = sel8_reg[BOOT_SEL_LSB +: 3];
    assign f_hrst = sel9_reg[HOST_RST_LSB +: 3];
    assign f_tclk = sel9_reg[HIZ_CLK_LSB +: 3];
    assign f_rts = sel9_reg[LOW_RTS_LSB +: 3];
    assign f_tx = sel9_reg[LOW_TX_LSB +: 3];
    assign f_dout = sel9_reg[MCS_DOUT_LSB +: 3];
    assign f_breq = sel9_reg[BCLK_REQ_LSB +: 3];
    assign f_bclk = selA_reg[BCLK_OUT_LSB +: 3];
    assign f_sync = selA_reg[MCS_SYNC_LSB +: 3];
    assign gate2 = gio9_s & pio3_s;

    // reserved codes leave the pad floating as the safe choice
    always_comb begin
        d_boot = PAD_HIZ;
        if (f_boot == SEL_2) begin
            d_boot = '{out: i_usb_port1_suspend_out, oe_n: 1'b0};
        end
        unique case (f_hrst)
            SEL_0: d_hrst = '{out: i_host_reset_out, oe_n: 1'b0};
            SEL_1: d_hrst = '{out: i_serial_port3_transmit_data,
                oe_n: 1'b0};
            SEL_2: d_hrst = '{out: i_usb_port1_single_ended_zero,
                oe_n: 1'b0};
            default: d_hrst = PAD_HIZ;
        endcase
        unique case (f_tclk)
            SEL_1: d_tclk = '{out: i_serial_port3_transmit_clock,
                oe_n: i_serial_port3_clock_dir_n};
            SEL_2: d_tclk = '{out: i_usb_port1_transmit_enable,
                oe_n: 1'b0};
            default: d_tclk = PAD_HIZ;
        endcase
        d_rts = PAD_HIZ;
        if (f_rts == SEL_0) begin
            d_rts = PAD_LOW;
        end else if (f_rts == SEL_1) begin
            d_rts = '{out: i_uart_a_request_to_send, oe_n: 1'b0};
        end
        d_tx = PAD_HIZ;
        if (f_tx == SEL_0) begin
            d_tx = PAD_LOW;
        end else if (f_tx == SEL_1) begin
            d_tx = '{out: i_uart_a_transmit, oe_n: 1'b0};
        end
        d_dout = PAD_HIZ;
        if (f_dout == SEL_0) begin
            d_dout = '{out: i_multichannel_serial_a_data_out,
                oe_n: 1'b0};
        end else if (f_dout == SEL_1) begin
            // usb and alternate uart share the code; either may drive
            d_dout = '{out: i_usb_port1_transmit_data | i_uart_a_tx_alt,
                oe_n: 1'b0};
        end
        unique case (f_bclk)
            SEL_0: d_bclk = '{out: i_bus_clock_out, oe_n: 1'b0};
            SEL_1: d_bclk = '{out: i_uart_c_request_to_send,
                oe_n: 1'b0};
            SEL_2: d_bclk = '{out: i_uart_a_data_terminal_ready,
                oe_n: 1'b0};
            default: d_bclk = PAD_HIZ;
        endcase
        d_sync = PAD_HIZ;
        if (f_sync == SEL_0) begin
            d_sync = '{out: i_multichannel_serial_a_sync,
                oe_n: i_sync_dir_n};
        end
    end

    // ********************************************************
    // pad cells: reset state, battery-fail gating, tri-state
    // ********************************************************
    out_pad_cell #(.GATE_ON_FAIL(1'b0), .RESET_DRIVE(PAD_HIZ)) u_boot (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_fail(fail_s), .i_gate2(1'b0),
        .i_func(d_boot), .o_pad(o_boot_pad));
    out_pad_cell #(.RESET_DRIVE(PAD_LOW)) u_hrst (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_fail(fail_s), .i_gate2(gate2),
        .i_func(d_hrst), .o_pad(o_host_rst_pad));
    out_pad_cell #(.RESET_DRIVE(PAD_HIZ)) u_tclk (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_fail(fail_s), .i_gate2(gate2),
        .i_func(d_tclk), .o_pad(o_tclk_pad));
    out_pad_cell #(.RESET_DRIVE(PAD_LOW)) u_rts (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_fail(fail_s), .i_gate2(gate2),
        .i_func(d_rts), .o_pad(o_rts_pad));
    out_pad_cell #(.RESET_DRIVE(PAD_LOW)) u_tx (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_fail(fail_s), .i_gate2(gate2),
        .i_func(d_tx), .o_pad(o_tx_pad));
    out_pad_cell #(.HIZ_ON_FAIL(1'b1), .RESET_DRIVE(PAD_LOW)) u_dout (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_fail(fail_s), .i_gate2(gate2),
        .i_func(d_dout), .o_pad(o_mcs_dout_pad));
    out_pad_cell #(.RESET_DRIVE(PAD_LOW)) u_bclk (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_fail(fail_s), .i_gate2(gate2),
        .i_func(d_bclk), .o_pad(o_bclk_pad));
    out_pad_cell #(.RESET_DRIVE(PAD_HIZ)) u_sync (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_fail(fail_s), .i_gate2(gate2),
        .i_func(d_sync), .o_pad(o_sync_pad));

    // ********************************************************
    // input routing with deselected levels, and scan chain
    // ********************************************************
    logic [7:0] in_reg;
    logic [7:0] in_next;
    logic [7:0] scan_reg;
    logic [7:0] scan_next;

    // scan mode substitutes the chain capture for pin samples
    always_comb begin
        in_next[0] = (f_boot == SEL_0) ? boot_s : DESEL_DEFAULT;
        in_next[1] = (f_boot == SEL_1) ? boot_s : DESEL_DEFAULT;
        in_next[2] = (f_tclk == SEL_1) ? tclk_s : DESEL_DEFAULT;
        in_next[3] = (f_breq == SEL_0) ? breq_s : DESEL_BCLK_REQ;
        in_next[4] = (f_breq == SEL_1) ? breq_s : DESEL_UART_C_CTS;
        in_next[5] = (f_breq == SEL_2) ? breq_s : DESEL_UART_A_DSR;
        in_next[6] = (f_sync == SEL_0) ? sync_s : DESEL_MCS_SYNC;
        in_next[7] = (f_sync == SEL_1) ? sync_s : DESEL_DEFAULT;
        scan_next = scan_reg;
        if (i_scan_shift) begin
            scan_next = {scan_reg[6:0], i_scan_in};
        end else if (i_scan_mode) begin
            scan_next = {boot_s, tclk_s, breq_s, sync_s,
                o_host_rst_pad.out, o_rts_pad.out, o_tx_pad.out,
                o_bclk_pad.out};
        end
        if (i_scan_mode) begin
            in_next = scan_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            in_reg <= 8'h20; // dsr idles high
            scan_reg <= 8'h00;
        end else begin
            in_reg <= in_next;
            scan_reg <= scan_next;
        end
    end

    assign o_boot_select_input = in_reg[0];
    assign o_serial_port3_receive_data = in_reg[1];
    assign o_serial_port3_clock_in = in_reg[2];
    assign o_bus_clock_request = in_reg[3];
    assign o_uart_c_clear_to_send = in_reg[4];
    assign o_uart_a_data_set_ready = in_reg[5];
    assign o_multichannel_serial_a_sync = in_reg[6];
    assign o_usb_port1_plus_receive = in_reg[7];
    assign o_scan_out = scan_reg[7];

endmodule

// *** testbench/pin_mux_props.sv ***
// checker for the terminal function mux slice, top ports only.
// assumes i_clk single domain, i_rstn async active low.
`timescale 1ns/10ps
module pin_mux_props
    import pin_mux_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_battery_fail_input,
    input wire pad_drive_t o_boot_pad,
    input wire pad_drive_t o_host_rst_pad,
    input wire pad_drive_t o_tclk_pad,
    input wire pad_drive_t o_rts_pad,
    input wire pad_drive_t o_tx_pad,
    input wire pad_drive_t o_mcs_dout_pad,
    input wire pad_drive_t o_bclk_pad,
    input wire pad_drive_t o_sync_pad,
    input wire logic o_boot_select_input,
    input wire logic o_serial_port3_receive_data,
    input wire logic o_bus_clock_request,
    input wire logic o_uart_c_clear_to_send,
    input wire logic o_uart_a_data_set_ready,
    input wire logic o_multichannel_serial_a_sync,
    input wire logic o_usb_port1_plus_receive
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // read data only stands in the cycle after a read
    a_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside answer");
    // eight cycles covers the three-flop sync plus pad register
    a_dout_float_fail: assert property (
        i_battery_fail_input [*8] |-> o_mcs_dout_pad.oe_n)
        else $error("serial data pad driven in battery fail");
    a_host_gate_low: assert property (
        i_battery_fail_input [*8] |-> !o_host_rst_pad.out)
        else $error("host reset pad not gated in battery fail");
    a_dsr_select_excl: assert property (
        !o_uart_a_data_set_ready |->
            !o_bus_clock_request && !o_uart_c_clear_to_send)
        else $error("deselected inputs not at idle level");
    a_breq_excl: assert property (
        o_bus_clock_request |-> !o_uart_c_clear_to_send)
        else $error("request and clear to send both routed");
    a_sync_excl: assert property (
        o_usb_port1_plus_receive |-> !o_multichannel_serial_a_sync)
        else $error("deselected sync input not low");
    a_boot_excl: assert property (
        o_boot_select_input |-> !o_serial_port3_receive_data)
        else $error("boot and receive data both routed");
    // registered pads still show the reset state at the release edge
    a_reset_drive_low: assert property (
        $rose(i_rstn) |-> o_host_rst_pad == PAD_LOW &&
            o_bclk_pad == PAD_LOW && o_mcs_dout_pad == PAD_LOW &&
            o_rts_pad == PAD_LOW && o_tx_pad == PAD_LOW)
        else $error("pad not driven low in reset");
    a_reset_float: assert property (
        $rose(i_rstn) |-> o_tclk_pad.oe_n && o_sync_pad.oe_n &&
            o_boot_pad.oe_n && o_uart_a_data_set_ready)
        else $error("pad driven or input wrong in reset");
endmodule

// *** testbench/pin_board_model.sv ***
// board side of the shared terminals.
// assumes pad structs from the slice; board drives when pads float.
`timescale 1ns/10ps
module pin_board_model
    import pin_mux_pkg::*;
(
    input wire logic i_board,
    input wire pad_drive_t i_boot_pad,
    input wire pad_drive_t i_tclk_pad,
    input wire pad_drive_t i_sync_pad,
    output logic o_boot_pin,
    output logic o_tclk_pin,
    output logic o_sync_pin,
    output logic o_breq_pin
);
    // wire level: the pad wins while driven, else the board level
    assign o_boot_pin = i_boot_pad.oe_n ? i_board : i_boot_pad.out;
    assign o_tclk_pin = i_tclk_pad.oe_n ? i_board : i_tclk_pad.out;
    assign o_sync_pin = i_sync_pad.oe_n ? i_board : i_sync_pad.out;
    assign o_breq_pin = i_board;
endmodule

// *** testbench/terminal_function_mux_slice_bench.sv ***
// bench for the terminal function mux slice.
// assumes the board model and checker files are compiled first.
`timescale 1ns/10ps
module terminal_function_mux_slice_bench
    import pin_mux_pkg::*;
;
    // ********************************************************
    // stimulus and observed signals
    // ********************************************************
    // terminal kinds per code, two bits a terminal: 0 float 1 low 2 src
    localparam logic [15:0] KIND [3] = '{16'hA948, 16'h2AA8, 16'h202A};
    // sources routed per code
    localparam logic [14:0] MASK [3] = '{15'h4902, 15'h16D4, 15'h2029};
    logic i_clk = 0, i_rstn = 0, i_wr = 0, i_rd = 0;
    logic [3:0] i_addr = 0;
    logic [31:0] i_wdata = 0, o_rdata, w9;
    logic fail = 0, io9 = 0, io3 = 0, board = 0, sm = 0, ss = 0, si = 0;
    logic [14:0] src = 0;
    logic [7:0] ins, exp_in;
    logic pb, pt, ps, pq, so;
    pad_drive_t pads [8];
    int mismatches = 0, num_checks = 0, cycles = 0;

    terminal_function_mux_slice terminal_function_mux_slice_inst (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_battery_fail_input(fail), .i_general_io_nine(io9),
        .i_processor_io_three(io3), .i_scan_mode(sm),
        .i_scan_shift(ss), .i_scan_in(si), .o_scan_out(so),
        .i_boot_pin(pb), .o_boot_pad(pads[0]), .o_host_rst_pad(pads[1]),
        .o_tclk_pad(pads[2]), .i_tclk_pin(pt), .o_rts_pad(pads[3]),
        .o_tx_pad(pads[4]), .o_mcs_dout_pad(pads[5]), .i_breq_pin(pq),
        .o_bclk_pad(pads[6]), .o_sync_pad(pads[7]), .i_sync_pin(ps),
        .i_usb_port1_suspend_out(src[0]), .i_host_reset_out(src[1]),
        .i_serial_port3_transmit_data(src[2]),
        .i_usb_port1_single_ended_zero(src[3]),
        .i_serial_port3_transmit_clock(src[4]),
        .i_serial_port3_clock_dir_n(1'b0),
        .i_usb_port1_transmit_enable(src[5]),
        .i_uart_a_request_to_send(src[6]), .i_uart_a_transmit(src[7]),
        .i_multichannel_serial_a_data_out(src[8]),
        .i_usb_port1_transmit_data(src[9]), .i_uart_a_tx_alt(src[10]),
        .i_bus_clock_out(src[11]), .i_uart_c_request_to_send(src[12]),
        .i_uart_a_data_terminal_ready(src[13]),
        .i_multichannel_serial_a_sync(src[14]), .i_sync_dir_n(1'b0),
        .o_boot_select_input(ins[0]),
        .o_serial_port3_receive_data(ins[1]),
        .o_serial_port3_clock_in(ins[7]), .o_bus_clock_request(ins[2]),
        .o_uart_c_clear_to_send(ins[3]),
        .o_uart_a_data_set_ready(ins[4]),
        .o_multichannel_serial_a_sync(ins[5]),
        .o_usb_port1_plus_receive(ins[6]));

    pin_board_model pin_board_model_inst (.i_board(board),
        .i_boot_pad(pads[0]), .i_tclk_pad(pads[2]), .i_sync_pad(pads[7]),
        .o_boot_pin(pb), .o_tclk_pin(pt), .o_sync_pin(ps), .o_breq_pin(pq));

    // ********************************************************
    // tasks
    // ********************************************************
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(logic [3:0] a, logic [31:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk("read data", o_rdata, exp);
    endtask
    // pins pass three sync flops and a register
    task automatic settle;
        repeat (6) @(posedge i_clk);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ********************************************************
    // clock, timeout and tests
    // ********************************************************
    initial forever #5 i_clk = ~i_clk;
    // hang guard, the run needs just over a hundred cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            final_report;
        end
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(FUNC_SEL_9_OFFSET, FUNC_SEL_RESET);
        rd(4'h2, READ_UNMAPPED);
        // codes 0 to 2 on every field; code 2 is reserved on four fields
        for (int c = 0; c < 3; c++) begin
            w9 = 32'(c) * 32'h0920_1009;
            wr(FUNC_SEL_8_OFFSET, 32'(c) << BOOT_SEL_LSB);
            wr(FUNC_SEL_9_OFFSET, w9);
            wr(FUNC_SEL_A_OFFSET, 32'(c) * 32'h9);
            rd(FUNC_SEL_9_OFFSET, w9);
            for (int p = 0; p < 2; p++) begin
                src <= p[0] ? MASK[c] : ~MASK[c];
                board <= p[0];
                settle;
                for (int k = 0; k < 8; k++) begin
                    case (KIND[c][2*k+:2])
                        2'h0: chk("float", 32'(pads[k].oe_n), 1);
                        2'h1: chk("low", 32'(pads[k]), 32'(PAD_LOW));
                        default: chk("pad", 32'(pads[k]), 2*p);
                    endcase
                end
                exp_in = {c == 1, c == 1, c == 0, 1'b1, c == 1, c == 0,
                    c == 1, c == 0} & {8{p[0]}} | {3'h0, c != 2, 4'h0};
                chk("inputs", 32'(ins), 32'(exp_in));
            end
        end
        wr(FUNC_SEL_9_OFFSET, FUNC_SEL_RESET);
        src <= '1;
        fail <= 1'b1;
        io9 <= 1'b1;
        settle;
        chk("dout float", 32'(pads[5].oe_n), 1);
        chk("host gated", 32'(pads[1].out), 0);
        wr(PAD_STATUS_OFFSET, '1);
        rd(PAD_STATUS_OFFSET, 32'h3);
        fail <= 1'b0;
        io3 <= 1'b1;
        settle;
        chk("gate two", 32'(pads[1].out), 0);
        rd(PAD_STATUS_OFFSET, 32'h6);
        ss <= 1'b1;
        for (int b = 7; b >= 0; b--) begin
            si <= 1'(8'hA5 >> b);
            @(posedge i_clk);
        end
        #1 chk("scan out", 32'(so), 1);
        sm <= 1'b1;
        @(posedge i_clk);
        {sm, ss} <= 2'b00;
        #1 chk("scan in", 32'(ins), 32'hD1);
        // second reset in mid-run clears the fields
        wr(FUNC_SEL_9_OFFSET, w9);
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(FUNC_SEL_9_OFFSET, FUNC_SEL_RESET);
        final_report;
    end
endmodule

bind terminal_function_mux_slice pin_mux_props pin_mux_props_inst (
    .i_clk, .i_rstn, .i_rd, .o_rdata, .i_battery_fail_input, .o_boot_pad,
    .o_host_rst_pad, .o_tclk_pad, .o_rts_pad, .o_tx_pad, .o_mcs_dout_pad,
    .o_bclk_pad, .o_sync_pad, .o_boot_select_input,
    .o_serial_port3_receive_data, .o_bus_clock_request,
    .o_uart_c_clear_to_send, .o_uart_a_data_set_ready,
    .o_multichannel_serial_a_sync, .o_usb_port1_plus_receive);
